// >>> verilog/uam_top.sv
`timescale 1ns/100ps
`include "uam_defines.svh"
// ==========================================
// Four-entry FIFO
module uam_fifo #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic flush,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  // Status
  output logic [W-1:0] rdata,
  output logic [2:0] count,
  output logic full,
  output logic empty
);
  logic [W-1:0] mem_q [4];
  logic [1:0] wp_q;
  logic [1:0] rp_q;
  logic [2:0] cnt_q;
  logic do_push;
  logic do_pop;
  assign do_push = push & (cnt_q != 3'h4);
  assign do_pop = pop & (cnt_q != 3'h0);
  assign rdata = mem_q[rp_q];
  assign count = cnt_q;
  assign full = (cnt_q == 3'h4);
  assign empty = (cnt_q == 3'h0);
  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem_q[wp_q] <= wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= 2'h0;
      rp_q <= 2'h0;
      cnt_q <= 3'h0;
    end
    else if (flush)
    begin
      wp_q <= 2'h0;
      rp_q <= 2'h0;
      cnt_q <= 3'h0;
    end
    else
    begin
      if (do_push)
      begin
        wp_q <= wp_q + 2'h1;
      end
      if (do_pop)
      begin
        rp_q <= rp_q + 2'h1;
      end
      cnt_q <= cnt_q + {2'h0, do_push} - {2'h0, do_pop};
    end
  end
endmodule : uam_fifo

// Function
// RULE1 - Enable bit gives pins to port per pin usage; cleared, pins released
// RULE2 - Stop-in-idle bit freezes port while device idles; auto-baud measurement still runs
// RULE3 - Infrared bit switches pulse coder on, only in 16x mode
// RULE4 - Request line mode: set simplex, cleared flow control
// RULE5 - Pin usage field picks transmit, receive, request, clear, baud clock pins
// RULE6 - Wake bit: falling edge in sleep interrupts, next rising edge clears bit
// RULE7 - Loopback bit feeds transmit line back into receiver
// RULE8 - Auto-baud measures next 0x55 character, then clears itself
// RULE9 - Receive polarity bit sets receive idle level
// RULE10 - High-speed bit gives 4 clocks per bit, else 16
// RULE11 - Format field: 8N, 8 even, 8 odd, 9N
// RULE12 - Stop select gives two stop bits, else one
// RULE13 - Transmit interrupt on load, on load emptying buffer, or on completion
// RULE14 - Software never writes transmit interrupt mode 11
// RULE15 - Transmit polarity bit sets transmit idle, plain or encoded
// RULE16 - Break bit sends start, twelve zeros, stop, then clears
// RULE17 - Transmit enable drives pin; clearing aborts and empties buffer
// RULE18 - Transmit full flag reads 1 only with buffer full
// RULE19 - Shift empty flag reads 1 with shifter and buffer empty, resets 1
// RULE20 - Transmit and receive buffers hold four characters each
// RULE21 - Baud generator divides clock by 16-bit prescaler
// RULE22 - Receive interrupt on any character, at three, or at four
// RULE23 - Clearing set overrun flag empties receive buffer and shifter
// RULE24 - Characters go least significant bit first: start, data, parity, stop
module uam_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire uam_pkg::uam_apb_req_t apb_req,
  output uam_pkg::uam_apb_rsp_t apb_rsp,
  // Device power state
  input wire logic idle_mode,
  input wire logic sleep_mode,
  // Serial pins
  input wire logic serial_in_pin,
  input wire logic clear_to_send_pin_n,
  output uam_pkg::uam_pins_t pins_out,
  // Events
  output logic tx_irq,
  output logic rx_irq,
  output logic wake_irq
);
  import uam_pkg::*;
  // ==========================================
  // Registers and shared decode
  logic [15:0] mode_q;
  logic [15:0] ctl_q;
  logic [15:0] brg_q;
  logic ovr_q;
  logic en;
  logic run;
  logic infrared_enable;
  logic [3:0] last;
  logic acc;
  logic wr;
  logic rd;
  logic [31:0] rd_v;
  logic hit;
  logic [15:0] stat_v;
  logic ovr_clr;
  logic ab_done;
  logic wake_clr;
  logic tx_end_brk;
  logic [1:0] fmt;
  assign en = mode_q[`UAM_M_EN];
  assign run = en & ~(mode_q[`UAM_M_SIDL] & idle_mode); // see RULE2
  assign infrared_enable = mode_q[`UAM_M_INFRARED_ENABLE] & ~mode_q[`UAM_M_BAUD_HIGH_SPEED]; // see RULE3
  assign last = mode_q[`UAM_M_BAUD_HIGH_SPEED] ? `UAM_LAST_4X : `UAM_LAST_16X; // see RULE10
  assign fmt = mode_q[`UAM_M_FMT];
  assign acc = apb_req.psel & apb_req.penable & apb_rsp.pready;
  assign wr = acc & apb_req.pwrite;
  assign rd = acc & ~apb_req.pwrite;
  assign ovr_clr = wr & (apb_req.paddr == `UAM_OFF_STAT) & ovr_q & ~apb_req.pwdata[`UAM_S_OVR];
  // ==========================================
  // Baud generator
  logic [15:0] bcnt_q;
  logic tick;
  logic [23:0] ab_cnt_q;
  logic [2:0] ab_edg_q;
  logic [23:0] ab_div;
  assign tick = run & (bcnt_q == brg_q);
  assign ab_div = mode_q[`UAM_M_BAUD_HIGH_SPEED] ? (ab_cnt_q >> 5) : (ab_cnt_q >> 7);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bcnt_q <= 16'h0000;
      brg_q <= `UAM_BRG_RST;
    end
    else
    begin
      if (!en)
      begin
        bcnt_q <= 16'h0000;
      end
      else if (run)
      begin
        bcnt_q <= tick ? 16'h0000 : bcnt_q + 16'h0001; // see RULE21
      end
      if (ab_done)
      begin
        brg_q <= ab_div[15:0] - 16'h0001; // see RULE8
      end
      if (wr && apb_req.paddr == `UAM_OFF_BRG)
      begin
        brg_q <= apb_req.pwdata[15:0];
      end
    end
  end
  // ==========================================
  // Transmit path
  logic [8:0] txf_rdata;
  logic [2:0] txf_cnt;
  logic txf_full;
  logic txf_empty;
  logic txf_push;
  logic txf_pop;
  uam_tx_st_t tx_st_q;
  logic [13:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [3:0] tx_sub_q;
  logic tx_brk_q;
  logic [13:0] frm_v;
  logic [3:0] len_v;
  logic tx_go;
  logic tx_step;
  logic tx_end;
  logic tx_bit;
  logic tx_enc;
  logic cts_ok;
  logic [2:0] cts_s_q;
  logic cts_q;
  logic [1:0] txisel;
  assign txisel = {ctl_q[`UAM_S_TXISEL1], ctl_q[`UAM_S_TXISEL0]};
  assign txf_push = wr & (apb_req.paddr == `UAM_OFF_TXD) & en & ctl_q[`UAM_S_TXEN];
  uam_fifo #(.W(9)) u_txf ( // see RULE20
    .clk(pclk),
    .rst_n(presetn),
    .flush(~en | ~ctl_q[`UAM_S_TXEN]), // see RULE17
    .push(txf_push),
    .wdata(apb_req.pwdata[8:0]),
    .pop(txf_pop),
    .rdata(txf_rdata),
    .count(txf_cnt),
    .full(txf_full),
    .empty(txf_empty)
  );
  always_comb
  begin
    frm_v = {4'hF, ^txf_rdata[7:0] ^ fmt[1], txf_rdata[7:0], 1'h0}; // see RULE11
    len_v = 4'hB;
    case (fmt)
      2'h0:
      begin
        frm_v = {5'h1F, txf_rdata[7:0], 1'h0}; // see RULE24
        len_v = 4'hA;
      end
      2'h3:
      begin
        frm_v = {4'hF, txf_rdata[8:0], 1'h0};
        len_v = 4'hB;
      end
      default:
      begin
        len_v = 4'hB;
      end
    endcase
    len_v = len_v + {3'h0, mode_q[`UAM_M_STOP_BIT_SELECT]}; // see RULE12
    if (ctl_q[`UAM_S_BRK])
    begin
      frm_v = 14'h2000; // see RULE16
      len_v = 4'hE;
    end
  end
  assign cts_ok = (mode_q[`UAM_M_UEN] != 2'h2) | ~cts_q; // see RULE5
  assign tx_go = run & ctl_q[`UAM_S_TXEN] & (tx_st_q == UAM_TX_IDLE) & cts_ok & (ctl_q[`UAM_S_BRK] | ~txf_empty);
  assign txf_pop = tx_go & ~ctl_q[`UAM_S_BRK];
  assign tx_step = tick & (tx_st_q == UAM_TX_SHIFT) & (tx_sub_q == last);
  assign tx_end = tx_step & (tx_left_q == 4'h1);
  assign tx_end_brk = tx_end & tx_brk_q;
  assign tx_bit = (tx_st_q == UAM_TX_SHIFT) ? tx_sh_q[0] : 1'h1;
  assign tx_enc = ~tx_bit & (tx_sub_q < `UAM_IR_PULSE); // see RULE3
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_q <= UAM_TX_IDLE;
      tx_sh_q <= 14'h3FFF;
      tx_left_q <= 4'h0;
      tx_sub_q <= 4'h0;
      tx_brk_q <= 1'h0;
    end
    else if (!en || !ctl_q[`UAM_S_TXEN])
    begin
      tx_st_q <= UAM_TX_IDLE; // see RULE17
      tx_sh_q <= 14'h3FFF;
      tx_sub_q <= 4'h0;
      tx_brk_q <= 1'h0;
    end
    else if (tx_go)
    begin
      tx_st_q <= UAM_TX_SHIFT;
      tx_sh_q <= frm_v;
      tx_left_q <= len_v;
      tx_sub_q <= 4'h0;
      tx_brk_q <= ctl_q[`UAM_S_BRK];
    end
    else if (tick && tx_st_q == UAM_TX_SHIFT)
    begin
      tx_sub_q <= (tx_sub_q == last) ? 4'h0 : tx_sub_q + 4'h1;
      if (tx_step)
      begin
        tx_sh_q <= {1'h1, tx_sh_q[13:1]}; // see RULE24
        tx_left_q <= tx_left_q - 4'h1;
        if (tx_end)
        begin
          tx_st_q <= UAM_TX_IDLE;
        end
      end
    end
  end
  // ==========================================
  // Receive input conditioning
  logic [2:0] rx_s_q;
  logic rx_stab_q;
  logic line_n;
  logic [3:0] ir_hold_q;
  logic rx_dec;
  logic rx_line_q;
  logic rx_prev_q;
  logic rx_fall;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_s_q <= 3'h7;
      rx_stab_q <= 1'h1;
      cts_s_q <= 3'h7;
      cts_q <= 1'h1;
    end
    else
    begin
      rx_s_q <= {rx_s_q[1:0], serial_in_pin};
      cts_s_q <= {cts_s_q[1:0], clear_to_send_pin_n};
      if (rx_s_q[1] == rx_s_q[2])
      begin
        rx_stab_q <= rx_s_q[2];
      end
      if (cts_s_q[1] == cts_s_q[2])
      begin
        cts_q <= cts_s_q[2];
      end
    end
  end
  assign line_n = rx_stab_q ^ mode_q[`UAM_M_RXINV]; // see RULE9
  assign rx_dec = infrared_enable ? (line_n & (ir_hold_q == 4'h0)) : line_n;
  assign rx_fall = rx_prev_q & ~rx_line_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ir_hold_q <= 4'h0;
      rx_line_q <= 1'h1;
      rx_prev_q <= 1'h1;
    end
    else
    begin
      if (infrared_enable && !line_n)
      begin
        ir_hold_q <= `UAM_IR_HOLD; // see RULE3
      end
      else if (tick && ir_hold_q != 4'h0)
      begin
        ir_hold_q <= ir_hold_q - 4'h1;
      end
      rx_line_q <= mode_q[`UAM_M_LPBK] ? tx_bit : rx_dec; // see RULE7
      rx_prev_q <= rx_line_q;
    end
  end
  // ==========================================
  // Auto-baud measurement
  logic ab_act;
  assign ab_act = en & mode_q[`UAM_M_AUTO_BAUD_ENABLE];
  assign ab_done = ab_act & rx_fall & (ab_edg_q == `UAM_AB_EDGES); // see RULE8
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ab_cnt_q <= 24'h000000;
      ab_edg_q <= 3'h0;
    end
    else if (!ab_act || ab_done)
    begin
      ab_cnt_q <= 24'h000000;
      ab_edg_q <= 3'h0;
    end
    else
    begin
      if (ab_edg_q != 3'h0 || rx_fall)
      begin
        ab_cnt_q <= ab_cnt_q + 24'h000001;
      end
      if (rx_fall)
      begin
        ab_edg_q <= ab_edg_q + 3'h1;
      end
    end
  end
  // ==========================================
  // Receive path
  uam_rx_st_t rx_st_q;
  logic [3:0] rx_sub_q;
  logic [3:0] rx_cnt_q;
  logic [9:0] rx_sh_q;
  logic [3:0] nb_v;
  logic rx_smp;
  logic rx_done;
  logic [9:0] rv;
  logic [10:0] rx_word;
  logic rx_keep;
  logic [10:0] rxf_rdata;
  logic [2:0] rxf_cnt;
  logic rxf_full;
  logic rxf_empty;
  logic rxf_push;
  assign nb_v = (fmt == 2'h0) ? 4'h9 : 4'hA;
  assign rx_smp = tick & (rx_st_q == UAM_RX_DATA) & (rx_sub_q == last);
  assign rx_done = rx_smp & (rx_cnt_q == nb_v - 4'h1);
  always_comb
  begin
    rv = {rx_line_q, rx_sh_q[9:1]};
    if (fmt == 2'h0)
    begin
      rv = rv >> 1;
    end
    case (fmt)
      2'h0: rx_word = {~rv[8], 1'h0, 1'h0, rv[7:0]};
      2'h3: rx_word = {~rv[9], 1'h0, rv[8:0]};
      default: rx_word = {~rv[9], rv[8] ^ (^rv[7:0]) ^ fmt[1], 1'h0, rv[7:0]}; // see RULE11
    endcase
  end
  assign rx_keep = ~(ctl_q[`UAM_S_ADDR] & (fmt == 2'h3) & ~rx_word[8]);
  assign rxf_push = rx_done & rx_keep & ~rxf_full;
  uam_fifo #(.W(11)) u_rxf ( // see RULE20
    .clk(pclk),
    .rst_n(presetn),
    .flush(~en | ovr_clr), // see RULE23
    .push(rxf_push),
    .wdata(rx_word),
    .pop(rd & (apb_req.paddr == `UAM_OFF_RXD)),
    .rdata(rxf_rdata),
    .count(rxf_cnt),
    .full(rxf_full),
    .empty(rxf_empty)
  );
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_q <= UAM_RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 10'h000;
    end
    else if (!en || ab_act || ovr_clr)
    begin
      rx_st_q <= UAM_RX_IDLE; // see RULE23
      rx_sub_q <= 4'h0;
    end
    else if (run)
    begin
      case (rx_st_q)
        UAM_RX_IDLE:
        begin
          if (rx_fall)
          begin
            rx_st_q <= UAM_RX_START;
            rx_sub_q <= 4'h0;
          end
        end
        UAM_RX_START:
        begin
          if (tick)
          begin
            rx_sub_q <= rx_sub_q + 4'h1;
            if (rx_sub_q == (last >> 1))
            begin
              rx_st_q <= rx_line_q ? UAM_RX_IDLE : UAM_RX_DATA;
              rx_sub_q <= 4'h0;
              rx_cnt_q <= 4'h0;
            end
          end
        end
        UAM_RX_DATA:
        begin
          if (tick)
          begin
            rx_sub_q <= (rx_sub_q == last) ? 4'h0 : rx_sub_q + 4'h1;
          end
          if (rx_smp)
          begin
            rx_sh_q <= {rx_line_q, rx_sh_q[9:1]}; // see RULE24
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_done)
            begin
              rx_st_q <= UAM_RX_IDLE;
            end
          end
        end
        default:
        begin
          rx_st_q <= UAM_RX_IDLE;
        end
      endcase
    end
  end
  // ==========================================
  // Wake on start edge
  logic wk_prev_q;
  logic wk_arm_q;
  logic wk_fall;
  assign wk_fall = en & mode_q[`UAM_M_WAKE] & sleep_mode & wk_prev_q & ~line_n;
  assign wake_clr = wk_arm_q & line_n & ~wk_prev_q; // see RULE6
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wk_prev_q <= 1'h1;
      wk_arm_q <= 1'h0;
    end
    else
    begin
      wk_prev_q <= line_n;
      if (!mode_q[`UAM_M_WAKE] || wake_clr)
      begin
        wk_arm_q <= 1'h0;
      end
      else if (wk_fall)
      begin
        wk_arm_q <= 1'h1;
      end
    end
  end
  // ==========================================
  // Control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= `UAM_MODE_RST;
      ctl_q <= `UAM_CTL_RST;
      ovr_q <= 1'h0;
    end
    else
    begin
      if (ab_done)
      begin
        mode_q[`UAM_M_AUTO_BAUD_ENABLE] <= 1'h0; // see RULE8
      end
      if (wake_clr)
      begin
        mode_q[`UAM_M_WAKE] <= 1'h0; // see RULE6
      end
      if (tx_end_brk)
      begin
        ctl_q[`UAM_S_BRK] <= 1'h0; // see RULE16
      end
      if (wr && apb_req.paddr == `UAM_OFF_MODE)
      begin
        mode_q <= apb_req.pwdata[15:0] & `UAM_MODE_WMASK;
      end
      if (wr && apb_req.paddr == `UAM_OFF_STAT)
      begin
        ctl_q <= apb_req.pwdata[15:0] & `UAM_STAT_WMASK;
      end
      if (ovr_clr)
      begin
        ovr_q <= 1'h0;
      end
      if (rx_done && rx_keep && rxf_full)
      begin
        ovr_q <= 1'h1;
      end
    end
  end
  // ==========================================
  // Register read and bus answer
  always_comb
  begin
    stat_v = ctl_q & `UAM_STAT_WMASK;
    stat_v[`UAM_S_TXFULL] = txf_full; // see RULE18
    stat_v[`UAM_S_SHEMPTY] = (tx_st_q == UAM_TX_IDLE) & txf_empty; // see RULE19
    stat_v[`UAM_S_RXIDLE] = (rx_st_q == UAM_RX_IDLE);
    stat_v[`UAM_S_PERR] = ~rxf_empty & rxf_rdata[9];
    stat_v[`UAM_S_FERR] = ~rxf_empty & rxf_rdata[10];
    stat_v[`UAM_S_OVR] = ovr_q;
    stat_v[`UAM_S_AVAIL] = ~rxf_empty;
    hit = 1'h1;
    case (apb_req.paddr)
      `UAM_OFF_MODE: rd_v = {16'h0000, mode_q};
      `UAM_OFF_STAT: rd_v = {16'h0000, stat_v};
      `UAM_OFF_TXD: rd_v = 32'h00000000;
      `UAM_OFF_RXD: rd_v = {23'h0, rxf_rdata[8:0]};
      `UAM_OFF_BRG: rd_v = {16'h0000, brg_q};
      default:
      begin
        rd_v = 32'h00000000;
        hit = 1'h0;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_rsp <= '0;
    end
    else
    begin
      apb_rsp.pready <= apb_req.psel & ~apb_req.penable & ~apb_rsp.pready;
      if (apb_req.psel && !apb_req.penable)
      begin
        apb_rsp.prdata <= apb_req.pwrite ? 32'h00000000 : rd_v;
        apb_rsp.pslverr <= ~hit;
      end
    end
  end
  // ==========================================
  // Pins and events
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins_out <= '0;
      pins_out.serial_out <= 1'h1;
      pins_out.request_to_send_n <= 1'h1;
      tx_irq <= 1'h0;
      rx_irq <= 1'h0;
      wake_irq <= 1'h0;
    end
    else
    begin
      pins_out.serial_out <= (infrared_enable ? tx_enc : tx_bit) ^ ctl_q[`UAM_S_TXINV]; // see RULE15
      pins_out.serial_out_oe <= en & ctl_q[`UAM_S_TXEN]; // see RULE1
      pins_out.request_to_send_oe <= en & (mode_q[`UAM_M_UEN] == 2'h1 || mode_q[`UAM_M_UEN] == 2'h2); // see RULE5
      pins_out.request_to_send_n <= mode_q[`UAM_M_REQUEST_LINE_MODE] ? (tx_st_q == UAM_TX_IDLE) : rxf_full; // see RULE4
      pins_out.bclk_oe <= en & (mode_q[`UAM_M_UEN] == 2'h3);
      if (tick)
      begin
        pins_out.bclk <= ~pins_out.bclk;
      end
      case (txisel) // see RULE13
        2'h2: tx_irq <= txf_pop & (txf_cnt == 3'h1);
        2'h1: tx_irq <= tx_end & txf_empty;
        default: tx_irq <= txf_pop; // see RULE14
      endcase
      case (ctl_q[`UAM_S_RXISEL]) // see RULE22
        2'h2: rx_irq <= rxf_push & (rxf_cnt == 3'h2);
        2'h3: rx_irq <= rxf_push & (rxf_cnt == 3'h3);
        default: rx_irq <= rxf_push;
      endcase
      wake_irq <= wk_fall & ~wk_arm_q; // see RULE6
    end
  end
endmodule : uam_top

// >>> verilog/uam_defines.svh
`ifndef UAM_DEFINES_SVH
`define UAM_DEFINES_SVH
// ==========================================
// Register byte offsets
`define UAM_OFF_MODE 8'h00
`define UAM_OFF_STAT 8'h04
`define UAM_OFF_TXD 8'h08
`define UAM_OFF_RXD 8'h0C
`define UAM_OFF_BRG 8'h10
// ==========================================
// Mode register fields
`define UAM_M_EN 15
`define UAM_M_SIDL 13
`define UAM_M_INFRARED_ENABLE 12
`define UAM_M_REQUEST_LINE_MODE 11
`define UAM_M_UEN 9:8
`define UAM_M_WAKE 7
`define UAM_M_LPBK 6
`define UAM_M_AUTO_BAUD_ENABLE 5
`define UAM_M_RXINV 4
`define UAM_M_BAUD_HIGH_SPEED 3
`define UAM_M_FMT 2:1
`define UAM_M_STOP_BIT_SELECT 0
`define UAM_MODE_WMASK 16'hBBFF
// ==========================================
// Status and control register fields
`define UAM_S_TXISEL1 15
`define UAM_S_TXINV 14
`define UAM_S_TXISEL0 13
`define UAM_S_BRK 11
`define UAM_S_TXEN 10
`define UAM_S_TXFULL 9
`define UAM_S_SHEMPTY 8
`define UAM_S_RXISEL 7:6
`define UAM_S_ADDR 5
`define UAM_S_RXIDLE 4
`define UAM_S_PERR 3
`define UAM_S_FERR 2
`define UAM_S_OVR 1
`define UAM_S_AVAIL 0
`define UAM_STAT_WMASK 16'hECE0
// ==========================================
// Reset values and timing counts
`define UAM_MODE_RST 16'h0000
`define UAM_CTL_RST 16'h0000
`define UAM_BRG_RST 16'h0000
`define UAM_LAST_4X 4'h3
`define UAM_LAST_16X 4'hF
`define UAM_IR_PULSE 4'h3
`define UAM_IR_HOLD 4'hF
`define UAM_AB_EDGES 3'h4
`endif

// >>> verilog/uam_pkg.sv
package uam_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } uam_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } uam_apb_rsp_t;
  typedef struct packed {
    logic serial_out;
    logic serial_out_oe;
    logic request_to_send_n;
    logic request_to_send_oe;
    logic bclk;
    logic bclk_oe;
  } uam_pins_t;
  typedef enum logic {UAM_TX_IDLE = 1'b0, UAM_TX_SHIFT = 1'b1} uam_tx_st_t;
  typedef enum logic [1:0] {UAM_RX_IDLE = 2'b00, UAM_RX_START = 2'b01, UAM_RX_DATA = 2'b10} uam_rx_st_t;
endpackage : uam_pkg

// >>> tb/uam_remote.sv
`timescale 1ns/100ps
// ========
// Remote serial node
module uam_remote (
  // Clock
  input wire logic pclk,
  // Line
  input wire logic line_in,
  output logic line_out
);
  int bclks = 32;
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_out <= f[i];
      repeat (bclks) @(posedge pclk);
    end
  endtask : send
  // Bits from a falling edge, mid-bit
  task automatic grab(input int n, output logic [15:0] v);
    int t;
    v = '1;
    t = 0;
    while (line_in !== 1'b0 && t < 5000)
    begin
      @(posedge pclk);
      t++;
    end
    repeat (bclks / 2) @(posedge pclk);
    for (int i = 0; i < n; i++)
    begin
      v[i] = line_in;
      repeat (bclks) @(posedge pclk);
    end
  endtask : grab
endmodule : uam_remote

// >>> tb/uam_top_assertions.sv
`timescale 1ns/100ps
// ========
// Port checker
module uam_top_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire uam_pkg::uam_apb_req_t apb_req,
  input wire uam_pkg::uam_apb_rsp_t apb_rsp,
  // State and pins
  input wire logic idle_mode,
  input wire logic sleep_mode,
  input wire uam_pkg::uam_pins_t pins_out,
  input wire logic tx_irq,
  input wire logic wake_irq
);
  import uam_pkg::*;
  logic [15:0] mode_q;
  logic [15:0] stat_q;
  wire wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
  // Shadow of written control
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mode_q <= 16'h0000;
    else if (wr && apb_req.paddr == 8'h00)
      mode_q <= apb_req.pwdata[15:0];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      stat_q <= 16'h0000;
    else if (wr && apb_req.paddr == 8'h04)
      stat_q <= apb_req.pwdata[15:0];
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ========
  // Properties
  property p_rdy;
    apb_req.psel && !apb_req.penable |=> apb_rsp.pready ##1 !apb_rsp.pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready timing");
  property p_err;
    apb_req.psel && !apb_req.penable && apb_req.paddr > 8'h10 |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access");
  property p_off;
    !mode_q[15] [*2] |-> !pins_out.serial_out_oe && !pins_out.request_to_send_oe && !pins_out.bclk_oe;
  endproperty
  a_off: assert property (p_off) else $error("pins driven while off");
  property p_uen;
    (mode_q[9:8] == 2'b00) [*2] |-> !pins_out.request_to_send_oe && !pins_out.bclk_oe;
  endproperty
  a_uen: assert property (p_uen) else $error("extra pins driven");
  property p_txen;
    !stat_q[10] [*2] |-> !pins_out.serial_out_oe;
  endproperty
  a_txen: assert property (p_txen) else $error("tx pin driven");
  property p_txirq;
    tx_irq |=> !tx_irq;
  endproperty
  a_txirq: assert property (p_txirq) else $error("tx irq too long");
  property p_wake;
    !sleep_mode [*8] |-> !wake_irq;
  endproperty
  a_wake: assert property (p_wake) else $error("wake outside sleep");
  property p_freeze;
    (mode_q[13] && idle_mode) [*5] |-> $stable(pins_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("pins move in idle");
  c_txirq: cover property (tx_irq);
  c_wake: cover property (wake_irq);
  c_err: cover property (apb_rsp.pslverr);
endmodule : uam_top_chk
bind uam_top uam_top_chk u_uam_top_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .idle_mode(idle_mode), .sleep_mode(sleep_mode), .pins_out(pins_out), .tx_irq(tx_irq), .wake_irq(wake_irq));

// >>> tb/tb_uam_top.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
// ========
// Bench
module tb_uam_top;
  import uam_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  uam_apb_req_t req = '0;
  uam_apb_rsp_t rsp;
  logic idle_mode = 1'b0;
  logic sleep_mode = 1'b0;
  logic cts_n = 1'b1;
  logic rx_line;
  logic line;
  uam_pins_t pins;
  logic tx_irq;
  logic rx_irq;
  logic wake_irq;
  logic [31:0] rdat;
  logic rerr;
  logic [15:0] v;
  int mismatches = 0;
  int compares = 0;
  int ntx = 0;
  int nrx = 0;
  int nwk = 0;
  always #4 pclk = ~pclk;
  assign line = pins.serial_out_oe ? pins.serial_out : 1'b1;
  always @(posedge pclk)
  begin
    ntx += tx_irq;
    nrx += rx_irq;
    nwk += wake_irq;
  end
  uam_top u_uam_top (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .idle_mode(idle_mode),
    .sleep_mode(sleep_mode), .serial_in_pin(rx_line), .clear_to_send_pin_n(cts_n), .pins_out(pins),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .wake_irq(wake_irq));
  uam_remote u_uam_remote (.pclk(pclk), .line_in(line), .line_out(rx_line));
  // ========
  // Bus cycle
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, {16'h0000, d}};
    @(posedge pclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
    @(posedge pclk);
    if (n >= 20)
    begin
      mismatches++;
      results();
    end
  endtask : acc
  task automatic results;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  // ========
  // Scenarios
  task automatic t_reset;
    acc(0, 8'h00, 16'h0000);
    `CHK("mode", 32'h0, rdat)
    acc(0, 8'h04, 16'h0000);
    `CHK("status", 32'h110, rdat)
    `CHK("idle", 1'b1, pins.serial_out)
    acc(0, 8'h14, 16'h0000);
    `CHK("unmapped", 33'h100000000, {rerr, rdat})
  endtask : t_reset
  task automatic t_fmt;
    logic [10:0] e;
    acc(1, 8'h10, 16'h0001);
    acc(1, 8'h04, 16'h0400);
    for (int f = 0; f < 4; f++)
    begin
      acc(1, 8'h00, 16'h8000 | 16'(f << 1));
      ntx = 0;
      acc(1, 8'h08, 16'h01A5);
      u_uam_remote.grab(11, v);
      e = {1'b1, (f == 3) ? 9'h1A5 : {f != 1, 8'hA5}, 1'b0};
      `CHK("frame", e, v[10:0])
      `CHK("txirq", 1'b1, ntx > 0)
    end
  endtask : t_fmt
  task automatic t_stop;
    acc(1, 8'h00, 16'h8009);
    u_uam_remote.bclks = 8;
    acc(1, 8'h08, 16'h0000);
    acc(1, 8'h08, 16'h0000);
    u_uam_remote.grab(12, v);
    `CHK("stops", 3'b011, v[11:9])
    u_uam_remote.bclks = 32;
  endtask : t_stop
  task automatic t_full;
    acc(1, 8'h00, 16'h8000);
    for (int i = 0; i < 6; i++)
      acc(1, 8'h08, 16'(i));
    acc(0, 8'h04, 16'h0000);
    `CHK("full", 2'b10, rdat[9:8])
    acc(1, 8'h04, 16'h0000);
    acc(0, 8'h04, 16'h0000);
    `CHK("flushed", 2'b01, rdat[9:8])
    `CHK("oe", 1'b0, pins.serial_out_oe)
  endtask : t_full
  task automatic t_break;
    acc(1, 8'h04, 16'h0C00);
    u_uam_remote.grab(14, v);
    `CHK("break", 14'h2000, v[13:0])
    acc(0, 8'h04, 16'h0000);
    `CHK("brkclr", 1'b0, rdat[11])
    acc(1, 8'h04, 16'h4400);
    repeat (3) @(posedge pclk);
    `CHK("inv", 1'b0, pins.serial_out)
    acc(1, 8'h04, 16'h0400);
  endtask : t_break
  task automatic t_rx;
    nrx = 0;
    u_uam_remote.send(8'h3C);
    acc(0, 8'h0C, 16'h0000);
    `CHK("rxdata", 9'h03C, rdat[8:0])
    `CHK("rxirq", 1'b1, nrx > 0)
  endtask : t_rx
  task automatic t_loop;
    acc(1, 8'h00, 16'h8040);
    acc(1, 8'h08, 16'h00C3);
    rdat = '0;
    for (int i = 0; i < 200 && rdat[0] !== 1'b1; i++)
      acc(0, 8'h04, 16'h0000);
    acc(0, 8'h0C, 16'h0000);
    `CHK("loop", 9'h0C3, rdat[8:0])
  endtask : t_loop
  task automatic t_pins;
    for (int u = 0; u < 4; u++)
    begin
      acc(1, 8'h00, 16'h8000 | 16'(u << 8));
      repeat (3) @(posedge pclk);
      `CHK("pinoe", {u == 1 || u == 2, u == 3}, {pins.request_to_send_oe, pins.bclk_oe})
    end
    acc(1, 8'h00, 16'h0000);
    repeat (3) @(posedge pclk);
    `CHK("alloff", 1'b0, pins.serial_out_oe)
  endtask : t_pins
  task automatic t_idle;
    acc(1, 8'h00, 16'hA000);
    acc(1, 8'h08, 16'h0055);
    repeat (40) @(posedge pclk);
    idle_mode <= 1'b1;
    repeat (40) @(posedge pclk);
    idle_mode <= 1'b0;
    rdat = '0;
    for (int i = 0; i < 200 && rdat[8] !== 1'b1; i++)
      acc(0, 8'h04, 16'h0000);
    `CHK("resume", 1'b1, rdat[8])
  endtask : t_idle
  task automatic t_wake;
    acc(1, 8'h00, 16'h8080);
    sleep_mode <= 1'b1;
    nwk = 0;
    u_uam_remote.send(8'hFE);
    sleep_mode <= 1'b0;
    `CHK("wakeirq", 1'b1, nwk > 0)
    acc(0, 8'h00, 16'h0000);
    `CHK("wakeclr", 1'b0, rdat[7])
  endtask : t_wake
  task automatic t_auto_baud_enable;
    acc(1, 8'h00, 16'h8020);
    u_uam_remote.bclks = 64;
    u_uam_remote.send(8'h55);
    acc(0, 8'h10, 16'h0000);
    `CHK("auto_baud_enable", 32'h3, rdat)
  endtask : t_auto_baud_enable
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_fmt();
    t_stop();
    t_full();
    t_break();
    t_rx();
    t_loop();
    t_pins();
    t_idle();
    t_wake();
    t_auto_baud_enable();
    results();
  end
endmodule : tb_uam_top
